// ---- src/tsic_pkg.sv ----
// package for the three source interrupt control block
package tsic_pkg;
	// apb register byte offsets
	localparam logic [7:0] TSIC_CTRL_OFS   = 8'h00;   // irq_control_reg
	localparam logic [7:0] TSIC_STAT_OFS   = 8'h04;   // sticky event status, clear on read
	localparam logic [7:0] TSIC_MASK_OFS   = 8'h08;   // status interrupt mask
	localparam logic [7:0] TSIC_SP_OFS     = 8'h0C;   // stack depth, read only
	// irq_control_reg field positions
	localparam int TSIC_GIE_BIT  = 0;                 // global_irq_enable
	localparam int TSIC_EEN_BIT  = 1;                 // ext_irq_enable
	localparam int TSIC_TEN_BIT  = 2;                 // timer_irq_enable
	localparam int TSIC_CEN_BIT  = 3;                 // conv_irq_enable
	localparam int TSIC_EFL_BIT  = 4;                 // ext_irq_flag
	localparam int TSIC_TFL_BIT  = 5;                 // timer_irq_flag
	localparam int TSIC_CFL_BIT  = 6;                 // conv_irq_flag
	// reset values
	localparam logic [6:0] TSIC_CTRL_RST = 7'h00;
	localparam logic [2:0] TSIC_MASK_RST = 3'h0;
	// fixed vectors, low to high priority index: ext, timer, conv
	localparam logic [11:0] TSIC_VEC_EXT   = 12'h004;
	localparam logic [11:0] TSIC_VEC_TMR   = 12'h008;
	localparam logic [11:0] TSIC_VEC_CONV  = 12'h00C;
	localparam int TSIC_STACK_DEPTH = 6;
	localparam int TSIC_PC_W        = 12;

	// core handshake towards the program counter and return stack
	typedef struct packed {
		logic        take;    // one-cycle pulse: push and jump
		logic [11:0] vector;  // address to load
	} tsic_accept_s;

	// sticky status event set
	typedef struct packed {
		logic conv;
		logic tmr;
		logic ext;
	} tsic_evt_s;

	typedef enum logic [1:0]
	{
		TSIC_SRC_EXT  = 2'b00,
		TSIC_SRC_TMR  = 2'b01,
		TSIC_SRC_CONV = 2'b10,
		TSIC_SRC_NONE = 2'b11
	} tsic_src_e;
endpackage : tsic_pkg

// ---- src/tsic_prio.sv ----
// fixed priority pick of pending sources
`timescale 1ns/10ps
module tsic_prio
	import tsic_pkg::*;
(
	input  wire logic [2:0]  req,     // enabled and pending, bit0 ext
	output tsic_src_e         src,     // winning source
	output logic [11:0]       vector   // its vector
);
	// external first, then timer, then conversion
	assign src    = req[0] ? TSIC_SRC_EXT : req[1] ? TSIC_SRC_TMR :
	                req[2] ? TSIC_SRC_CONV : TSIC_SRC_NONE;
	assign vector = req[0] ? TSIC_VEC_EXT : req[1] ? TSIC_VEC_TMR : TSIC_VEC_CONV;
endmodule : tsic_prio

// ---- src/tsic_stack.sv ----
// return stack depth tracker: counts pushes and pops
`timescale 1ns/10ps
module tsic_stack
	import tsic_pkg::*;
#(
	parameter int DEPTH = TSIC_STACK_DEPTH
)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       push,     // interrupt or call entry
	input  wire logic       pop,      // return
	output logic [3:0]      level,    // entries in use
	output logic            full      // no room for another push
);
	logic [3:0] level_reg;   // current depth
	logic [3:0] level_next;
	// saturating up/down; a simultaneous push and pop leaves the depth alone
	assign level_next = (push && !pop && level_reg != 4'(DEPTH)) ? level_reg + 4'h1 :
	                    (pop && !push && level_reg != 4'h0) ? level_reg - 4'h1 : level_reg;
	assign level = level_reg;
	assign full  = (level_reg == 4'(DEPTH));
	// depth register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_reg <= 4'h0;
		else
			level_reg <= level_next;
	end
endmodule : tsic_stack

// ---- src/tsic_top.sv ----
// three source interrupt control with apb registers
// Functional notes
// - three sources: external pin, timer, conversion
// - enables and flags share one control register
// - events set their own request flag
// - global enable clear blocks all service
// - accept: push return address, jump vector
// - return pops saved program counter
// - service clears global enable automatically
// - flags still latch while globally blocked
// - full stack holds off acknowledgement
// - vectors 04h, 08h, 0ch fixed
// - priority external, timer, conversion
// - external flag on falling edge only
// - service clears serviced source flag
//
// register map, one aligned 32-bit word each, unused bits read zero:
//   control  - bit0 global enable, bits1..3 source enables (ext, timer, conv),
//              bits4..6 request flags in the same order; software can only
//              clear a flag (write 0), never set one
//   status   - sticky copy of the three events, cleared by the read that
//              returned them; an event in the same cycle survives the clear
//   mask     - selects which status bits drive the irq summary output
//   depth    - return stack entries in use, read only
//
// limitations and trade-offs:
//   the apb answer is one registered cycle after setup, so read data is
//   captured at the setup edge; the status clear therefore removes only the
//   bits that were actually returned, never a bit that arrived afterwards
//   acceptance is refused in the cycle after a take, so the core always sees
//   a single-cycle push request and the cleared global enable has settled
//   ordinary calls count towards the stack depth too, because a full stack
//   must hold off interrupts whatever filled it
//
`timescale 1ns/10ps
module tsic_top
	import tsic_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// event sources
	input  wire logic        ext_irq_n,     // external request pin, active low
	input  wire logic        timer_ovf,     // one-cycle overflow pulse
	input  wire logic        conv_done,     // one-cycle end of conversion pulse
	// core side
	input  wire logic        core_ready,    // core at an instruction boundary
	input  wire logic        core_reti,     // return-from-interrupt executed
	input  wire logic        core_call,     // ordinary call pushes too
	output tsic_accept_s      accept,       // push and jump request
	output logic             ret_pop,       // pop saved pc
	output logic             irq            // masked status summary
);
	logic [6:0] ctrl_reg;    // irq_control_reg
	logic [6:0] ctrl_next;
	logic [2:0] stat_reg;    // sticky event status
	logic [2:0] stat_next;
	logic [2:0] mask_reg;    // status interrupt mask
	logic       pin_d_reg;   // previous external pin level
	tsic_accept_s accept_reg;
	logic       pop_reg;
	logic       irq_reg;
	logic [31:0] rdata_reg;
	logic       ready_reg;
	logic       err_reg;

	// apb decode
	wire setup_ph  = psel && !penable;
	wire wr_ctrl   = psel && penable && pready && pwrite && paddr == TSIC_CTRL_OFS;
	wire wr_mask   = psel && penable && pready && pwrite && paddr == TSIC_MASK_OFS;
	wire rd_stat   = psel && penable && pready && !pwrite && paddr == TSIC_STAT_OFS;
	wire addr_ok   = paddr == TSIC_CTRL_OFS || paddr == TSIC_STAT_OFS ||
	                 paddr == TSIC_MASK_OFS || paddr == TSIC_SP_OFS;

	// source events
	wire ext_fall  = pin_d_reg && !ext_irq_n;
	wire [2:0] evt = {conv_done, timer_ovf, ext_fall};

	// stack depth
	logic [3:0] sp_level;
	logic       sp_full;
	wire  take;
	tsic_stack #(.DEPTH(TSIC_STACK_DEPTH)) u_stack
	(
		.pclk    (pclk),
		.presetn (presetn),
		.push    (take || core_call),
		.pop     (core_reti),
		.level   (sp_level),
		.full    (sp_full)
	);

	// pending = enabled and flagged
	wire [2:0] pend = ctrl_reg[6:4] & ctrl_reg[3:1];
	tsic_src_e  win_src;
	logic [11:0] win_vec;
	tsic_prio u_prio
	(
		.req    (pend),
		.src    (win_src),
		.vector (win_vec)
	);
	// acceptance: global enable, a winner, room on stack, core at boundary
	assign take = ctrl_reg[TSIC_GIE_BIT] && win_src != TSIC_SRC_NONE
	              && !sp_full && core_ready && !accept_reg.take;
	// one-hot clear of the serviced flag
	wire [2:0] svc_clr = take ? (3'b001 << win_src) : 3'b000;

	// control next value: software write, then hardware clears, then event sets
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
		begin
			ctrl_next[3:0] = pwdata[3:0];
			ctrl_next[6:4] = ctrl_reg[6:4] & pwdata[6:4];          // flags clear only
		end
		if (take)
		begin
			ctrl_next[TSIC_GIE_BIT] = 1'b0;
			ctrl_next[6:4] = ctrl_next[6:4] & ~svc_clr;
		end
		ctrl_next[6:4] = ctrl_next[6:4] | evt;
	end

	// status: clear on read, but a fresh event wins; only the bits that the
	// read returned are cleared, so an event landing after the setup-edge
	// capture of read data is kept for the next read instead of being lost
	assign stat_next = (rd_stat ? (stat_reg & ~rdata_reg[2:0]) : stat_reg) | evt;

	// control and status registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg  <= TSIC_CTRL_RST;
			stat_reg  <= 3'h0;
			mask_reg  <= TSIC_MASK_RST;
			pin_d_reg <= 1'b1;
		end
		else
		begin
			ctrl_reg  <= ctrl_next;
			stat_reg  <= stat_next;
			pin_d_reg <= ext_irq_n;
			if (wr_mask)
				mask_reg <= pwdata[2:0];
		end
	end

	// core handshake outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			accept_reg <= '0;
			pop_reg    <= 1'b0;
			irq_reg    <= 1'b0;
		end
		else
		begin
			accept_reg.take   <= take;
			accept_reg.vector <= take ? win_vec : accept_reg.vector;
			pop_reg           <= core_reti;
			irq_reg           <= |(stat_next & mask_reg);
		end
	end

	// read mux
	wire [31:0] rd_mux = (paddr == TSIC_CTRL_OFS) ? {25'h0, ctrl_reg} :
	                     (paddr == TSIC_STAT_OFS) ? {29'h0, stat_reg} :
	                     (paddr == TSIC_MASK_OFS) ? {29'h0, mask_reg} :
	                     (paddr == TSIC_SP_OFS)   ? {28'h0, sp_level} : 32'h0000_0000;

	// apb answer: no wait state, ready in first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
		end
		else
		begin
			ready_reg <= setup_ph;
			err_reg   <= setup_ph && !addr_ok;
			if (setup_ph && !pwrite)
				rdata_reg <= rd_mux;
		end
	end

	assign prdata  = rdata_reg;
	assign pready  = ready_reg;
	assign pslverr = err_reg;
	assign accept  = accept_reg;
	assign ret_pop = pop_reg;
	assign irq     = irq_reg;

	// assertions
	gie_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[TSIC_GIE_BIT] |=> !accept.take) else $error("accept while blocked");
	full_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		sp_full |=> !accept.take) else $error("accept with full stack");
	gie_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && !wr_ctrl |=> !ctrl_reg[TSIC_GIE_BIT]) else $error("gie not cleared");
	ext_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && pend[0] |=> accept.vector == 12'h004) else $error("ext vector");
	tmr_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && pend == 3'b110 |=> accept.vector == 12'h008) else $error("tmr vector");
	fall_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ext_irq_n) |=> ctrl_reg[TSIC_EFL_BIT]) else $error("ext flag missed");
	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		timer_ovf |=> ctrl_reg[TSIC_TFL_BIT]) else $error("timer flag missed");
	svc_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && win_src == TSIC_SRC_CONV && !conv_done |=> !ctrl_reg[TSIC_CFL_BIT])
		else $error("conv flag kept");
	pop_a: assert property (@(posedge pclk) disable iff (!presetn)
		core_reti |=> ret_pop) else $error("no pop");

	// a push request never lasts two cycles
	take_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		accept.take |=> !accept.take) else $error("take held two cycles");

	// global enable already cleared when the core sees the request
	take_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
		accept.take |-> !ctrl_reg[TSIC_GIE_BIT]) else $error("gie set at take");

	// conversion alone pending jumps to its own vector
	conv_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && pend == 3'b100 |=> accept.vector == 12'h00C) else $error("conv vector");

	// serviced external flag cleared unless a new edge arrives
	ext_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && win_src == TSIC_SRC_EXT && !ext_fall |=> !ctrl_reg[TSIC_EFL_BIT])
		else $error("ext flag kept");

	// serviced timer flag cleared unless a new overflow arrives
	tmr_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && win_src == TSIC_SRC_TMR && !timer_ovf |=> !ctrl_reg[TSIC_TFL_BIT])
		else $error("timer flag kept");

	// end of conversion always raises its flag
	conv_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |=> ctrl_reg[TSIC_CFL_BIT]) else $error("conv flag missed");

	// status copy of an overflow survives a same-cycle read
	stat_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		timer_ovf |=> stat_reg[1]) else $error("status event lost");

	// apb answer is a single-cycle pulse
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready held");

	// error only comes with the answer
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready) else $error("pslverr without pready");

	// irq only while some status bit is set
	irq_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> |stat_reg) else $error("irq without status");

	// software write sets enables and global enable directly
	sw_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl && !take |=> ctrl_reg[3:0] == $past(pwdata[3:0]))
		else $error("enable write lost");

	// external flag rises only on a pin edge, never by software
	flag_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_fall |=> !$rose(ctrl_reg[TSIC_EFL_BIT])) else $error("ext flag without edge");

	// no push while the core is between instructions
	core_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		!core_ready |=> !accept.take) else $error("take off boundary");

	// a pop request always follows a return
	pop_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		ret_pop |-> $past(core_reti)) else $error("pop without return");

	// acceptance decision itself refuses a full stack
	full_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		sp_full |-> !take) else $error("take with full stack");

	// mask register takes the written low bits
	mask_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_mask |=> mask_reg == $past(pwdata[2:0])) else $error("mask write lost");

	// pending external request always wins the pick
	ext_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
		take && pend[0] |-> win_src == TSIC_SRC_EXT) else $error("ext not first");
endmodule : tsic_top

// ---- tb/tsic_core_model.sv ----
// core model: program counter and return stack beside the interrupt block
`timescale 1ns/10ps
module tsic_core_model
	import tsic_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire tsic_accept_s accept,
	output logic [11:0]       pc,
	input  wire logic         ret_pop,
	output logic [3:0]        depth
);
	logic [11:0] stk [0:7];	// saved return addresses
	// the core idles at one address, so a clean return lands back on it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pc    <= 12'h100;
			depth <= 4'h0;
		end
		else if (accept.take)
		begin
			stk[depth[2:0]] <= pc;
			pc              <= accept.vector;
			depth           <= depth + 4'h1;
		end
		else if (ret_pop && depth != 4'h0)
		begin
			pc    <= stk[depth[2:0] - 3'h1];
			depth <= depth - 4'h1;
		end
endmodule : tsic_core_model

// ---- tb/tb_tsic_top.sv ----
// self-checking bench for the three source interrupt control
`timescale 1ns/10ps
module tb_tsic_top;
	import tsic_pkg::*;
	// one row: control written, events fired, take, vector, control read back
	typedef struct packed
	{
		logic [6:0]  ctl;
		logic [2:0]  ev;
		logic        tk;
		logic [11:0] vec;
		logic [6:0]  aft;
	} tsic_row_s;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err, got;
	logic         ext_irq_n, timer_ovf, conv_done, core_ready, core_reti, core_call;
	logic         ret_pop, irq;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [11:0]  pc;
	logic [3:0]   depth;
	tsic_accept_s accept;
	int           num_errors = 0;
	int           n_compared = 0;
	int           cycles = 0;
	// last two rows: globally blocked flags, then all three at once
	tsic_row_s    rows [5] = '{'{7'h03, 3'h1, 1'b1, 12'h004, 7'h02},
		'{7'h05, 3'h2, 1'b1, 12'h008, 7'h04}, '{7'h09, 3'h4, 1'b1, 12'h00C, 7'h08},
		'{7'h0E, 3'h7, 1'b0, 12'h100, 7'h7E}, '{7'h0F, 3'h7, 1'b1, 12'h004, 7'h6E}};

	tsic_top u_tsic_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_irq_n, .timer_ovf, .conv_done, .core_ready,
		.core_reti, .core_call, .accept, .ret_pop, .irq);
	tsic_core_model u_tsic_core_model (.pclk, .presetn, .accept, .pc, .ret_pop, .depth);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// one apb transfer; waits for pready, one idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// fire events, then watch a window of cycles for a take
	task automatic fire(input logic [2:0] ev);
		ext_irq_n <= ~ev[0];
		timer_ovf <= ev[1];
		conv_done <= ev[2];
		@(posedge pclk);
		timer_ovf <= 1'b0;
		conv_done <= 1'b0;
		got = 1'b0;
		repeat (8)
		begin
			@(posedge pclk);
			ext_irq_n <= 1'b1;
			if (accept.take === 1'b1)
				got = 1'b1;
		end
	endtask : fire

	// return from the service routine; the core must resume where it was
	task automatic reti();
		core_reti <= 1'b1;
		@(posedge pclk);
		core_reti <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("resume", 32'h0000_0100, {20'h0, pc});
	endtask : reti

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// hang guard: the whole run needs well under 1000 cycles
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			conclude();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, timer_ovf, conv_done, core_reti, core_call} = '0;
		{paddr, pwdata} = '0;
		ext_irq_n  = 1'b1;
		core_ready = 1'b1;	// core always at an instruction boundary
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, TSIC_CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		foreach (rows[i])
		begin
			apb(1'b1, TSIC_CTRL_OFS, {25'h0, rows[i].ctl});
			fire(rows[i].ev);
			chk("take", {31'h0, rows[i].tk}, {31'h0, got});
			chk("pc", {20'h0, rows[i].vec}, {20'h0, pc});
			if (got)
				reti();
			apb(1'b0, TSIC_CTRL_OFS, 32'h0);
			chk("ctrl", {25'h0, rows[i].aft}, rd);
		end
		// re-enable globally: the held timer flag is serviced next
		apb(1'b1, TSIC_CTRL_OFS, 32'h0000_006F);
		repeat (4) @(posedge pclk);
		chk("nest pc", 32'h0000_0008, {20'h0, pc});
		reti();
		// steady low pin must not set the flag again once cleared
		ext_irq_n <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b1, TSIC_CTRL_OFS, 32'h0000_0002);
		repeat (4) @(posedge pclk);
		apb(1'b0, TSIC_CTRL_OFS, 32'h0);
		chk("steady low", 32'h0000_0002, rd);
		ext_irq_n <= 1'b1;
		// fill the stack with calls; a timer request then waits for a return
		apb(1'b1, TSIC_MASK_OFS, 32'h0000_0007);
		core_call <= 1'b1;
		repeat (6) @(posedge pclk);
		core_call <= 1'b0;
		apb(1'b0, TSIC_SP_OFS, 32'h0);
		chk("depth", 32'h0000_0006, rd);
		apb(1'b1, TSIC_CTRL_OFS, 32'h0000_0005);
		apb(1'b0, TSIC_STAT_OFS, 32'h0);
		chk("status old", 32'h0000_0007, rd);
		fire(3'h2);
		chk("full take", 32'h0, {31'h0, got});
		chk("irq", 32'h0000_0001, {31'h0, irq});
		apb(1'b0, TSIC_STAT_OFS, 32'h0);
		chk("status", 32'h0000_0002, rd);
		core_reti <= 1'b1;
		@(posedge pclk);
		core_reti <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("late pc", 32'h0000_0008, {20'h0, pc});
		apb(1'b0, TSIC_STAT_OFS, 32'h0);
		chk("status clear", 32'h0, rd);
		repeat (2) @(posedge pclk);
		chk("irq low", 32'h0, {31'h0, irq});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0000_0001, {31'h0, err});
		chk("unmapped rd", 32'h0, rd);
		conclude();
	end
endmodule : tb_tsic_top
